// ===== lcf_consts.svh
// constants for the locked-card command filter
// assumes inclusion by the design modules, the checker and the bench
`ifndef LCF_CONSTS_SVH
`define LCF_CONSTS_SVH

// command indices
`define LCF_CMD_READ_SINGLE   6'h11
`define LCF_CMD_READ_MULTI    6'h12
`define LCF_CMD_TUNE_A        6'h13
`define LCF_CMD_TUNE_B        6'h16
`define LCF_CMD_BLOCK_COUNT   6'h17
`define LCF_CMD_WRITE_SINGLE  6'h18
`define LCF_CMD_WRITE_MULTI   6'h19
`define LCF_CMD_SET_BLOCKLEN  6'h10
`define LCF_CMD_EXT_READ_A    6'h30
`define LCF_CMD_EXT_WRITE_A   6'h31
`define LCF_CMD_EXT_READ_B    6'h3a
`define LCF_CMD_EXT_WRITE_B   6'h3b
`define LCF_CMD_LOCK_UNLOCK   6'h2a
`define LCF_CMD_OPT_A         6'h27
`define LCF_ACMD_SEC_A        6'h35
`define LCF_ACMD_SEC_B        6'h36
`define LCF_ACMD_OP_COND      6'h29
`define LCF_ACMD_PULLUP       6'h2a

// lock/unlock parameter nibble (erase, lock, clear, set)
`define LCF_LK_ERASE          4'h8
`define LCF_LK_0011           4'h3
`define LCF_LK_0111           4'h7
`define LCF_LK_0110           4'h6
`define LCF_LK_0010           4'h2
`define LCF_LK_0001           4'h1
`define LCF_LK_0101           4'h5

// extension busy hold: 1 s at 8 ns plus margin
`define LCF_EXT_BUSY_MS       1001
`define LCF_EXT_BUSY_CYC      (`LCF_EXT_BUSY_MS * 125000)

`endif

// ===== lcf_pkg.sv
// types for the locked-card command filter
// assumes lcf_consts.svh sits in the same folder
package lcf_pkg;
	typedef enum logic [2:0] {
		LCF_TGT_USER = 3'h1,
		LCF_TGT_BOOT = 3'h2,
		LCF_TGT_RPU  = 3'h4
	} lcf_target_e;

	typedef enum logic [2:0] {
		LCF_ST_IDLE = 3'h1,
		LCF_ST_BUSY = 3'h2,
		LCF_ST_DONE = 3'h4
	} lcf_busy_e;
endpackage : lcf_pkg

// ===== lcf_busy_timer.sv
// busy hold timer for non-performed extension writes
// assumes one clock, synchronous active-low reset
`timescale 1ns/10ps
`include "lcf_consts.svh"

module lcf_busy_timer #(
	parameter int unsigned HOLD_CYC = `LCF_EXT_BUSY_CYC
) (
	input  wire logic clk,
	input  wire logic resetn,
	input  wire logic start,
	output logic      busy
);
	lcf_pkg::lcf_busy_e state;
	logic [27:0]        count;

	// =====================================================
	// hold sequence
	always_ff @(posedge clk)
	begin
		if (!resetn)
		begin
			state <= lcf_pkg::LCF_ST_IDLE;
			count <= 28'h0;
		end
		else
		begin
			case (state)
				lcf_pkg::LCF_ST_IDLE:
				begin
					if (start)
					begin
						state <= lcf_pkg::LCF_ST_BUSY;
						count <= 28'(HOLD_CYC);
					end
				end
				lcf_pkg::LCF_ST_BUSY:
				begin
					if (count <= 28'h1)
						state <= lcf_pkg::LCF_ST_DONE;
					else
						count <= count - 28'h1;
				end
				lcf_pkg::LCF_ST_DONE:
					state <= lcf_pkg::LCF_ST_IDLE;
				default:
					state <= lcf_pkg::LCF_ST_IDLE;
			endcase
		end
	end

	assign busy = (state == lcf_pkg::LCF_ST_BUSY);
endmodule : lcf_busy_timer

// ===== lcf_filter.sv
// locked-card command filter: judges each command, builds status bits,
// resolves lock/unlock and force-erase outcomes per card type
// assumes command fields are held stable around CMD_VALID by the card's
// command decoder; CARD_CLK_IN is the host bus clock, sampled only
`timescale 1ns/10ps
`include "lcf_consts.svh"

module lcf_filter #(
	parameter bit          NEWER_TYPE      = 1'b1,
	parameter bit          HAS_ERASE_PWD   = 1'b1,
	parameter bit          HAS_SEC_BOOT    = 1'b1,
	parameter bit          HAS_SEC_DATA    = 1'b1,
	parameter bit          STD_CAPACITY    = 1'b0,
	parameter bit          HAS_PROT_CMDS   = 1'b1,
	parameter bit          HAS_TUNING      = 1'b1,
	parameter bit          HAS_BLOCK_COUNT = 1'b1,
	parameter bit          HAS_OPT_CMD     = 1'b1,
	parameter logic [3:0]  SEC_BOOT_FUNC   = 4'h1,
	parameter int unsigned EXT_BUSY_CYC    = `LCF_EXT_BUSY_CYC
) (
	input  wire logic       CLK,
	input  wire logic       RESETN,
	input  wire logic       CARD_CLK_IN,
	input  wire logic       CMD_VALID,
	input  wire logic [5:0] CMD_INDEX,
	input  wire logic       CMD_APP,
	input  wire logic       CMD_ERASE_CLASS,
	input  wire logic       CMD_PROTECT_CLASS,
	input  wire logic       CMD_BASIC_CLASS,
	input  wire logic [2:0] CMD_TARGET,
	input  wire logic [3:0] FUNCTION_NUMBER_FIELD,
	input  wire logic [3:0] LOCK_PARAM,
	input  wire logic       LOCK_ERASE_PWD_UNLOCK,
	input  wire logic       LOCK_SET_ERASE_PWD,
	input  wire logic       LOCK_CLR_ERASE_PWD,
	input  wire logic       LOCKED_IN,
	input  wire logic       REPLAY_AUTH_OK,
	input  wire logic       REPLAY_DISABLED,
	input  wire logic       ERASE_PWD_SET,
	input  wire logic       PERMANENT_PROTECT_BIT,
	input  wire logic       ERASE_DONE,
	output logic            CMD_ACCEPT,
	output logic            CMD_ILLEGAL,
	output logic            EXT_EXECUTE,
	output logic            EXT_SUPPRESS_DATA,
	output logic            EXT_BUSY,
	output logic            LOCKED_STATE_FLAG,
	output logic            RANGE_ERROR_FLAG,
	output logic            ILLEGAL_FLAG,
	output logic            LOCK_ERROR_FLAG,
	output logic            LOCK_EXECUTE,
	output logic [3:0]      LOCK_PARAM_EFF,
	output logic            ERASE_START,
	output logic            SET_PERMANENT_PROTECT,
	output logic            CLEAR_TEMP_PROTECTS,
	output logic            CLEAR_LOCK,
	output logic            WRITE_ERASE_PWD,
	output logic            CLEAR_ERASE_PWD,
	output logic            WRITE_USER_PWD,
	output logic            CLEAR_USER_PWD,
	output logic            CARD_CLK_EDGE
);
	// =====================================================
	// bus clock sampling; stage one feeds only stage two
	logic card_clk_s1;
	logic card_clk_s2;
	logic card_clk_s3;

	always_ff @(posedge CLK)
	begin
		if (!RESETN)
		begin
			card_clk_s1   <= 1'b0;
			card_clk_s2   <= 1'b0;
			card_clk_s3   <= 1'b0;
			CARD_CLK_EDGE <= 1'b0;
		end
		else
		begin
			card_clk_s1   <= CARD_CLK_IN;
			card_clk_s2   <= card_clk_s1;
			card_clk_s3   <= card_clk_s2;
			CARD_CLK_EDGE <= card_clk_s2 & ~card_clk_s3;
		end
	end

	// =====================================================
	// command classification
	logic is_user;
	logic is_boot;
	logic is_rpu;
	logic is_read;
	logic is_tune;
	logic is_write;
	logic is_ext;
	logic is_ext_read;
	logic is_lock_cmd;
	logic sec_fn;
	logic always_ok;
	logic next_accept;

	assign is_user     = (CMD_TARGET == lcf_pkg::LCF_TGT_USER);
	assign is_boot     = (CMD_TARGET == lcf_pkg::LCF_TGT_BOOT);
	assign is_rpu      = (CMD_TARGET == lcf_pkg::LCF_TGT_RPU);
	assign is_read     = !CMD_APP && (CMD_INDEX == `LCF_CMD_READ_SINGLE
		|| CMD_INDEX == `LCF_CMD_READ_MULTI);
	assign is_tune     = !CMD_APP && (CMD_INDEX == `LCF_CMD_TUNE_A
		|| CMD_INDEX == `LCF_CMD_TUNE_B);
	assign is_write    = !CMD_APP && (CMD_INDEX == `LCF_CMD_WRITE_SINGLE
		|| CMD_INDEX == `LCF_CMD_WRITE_MULTI);
	assign is_ext_read = !CMD_APP && (CMD_INDEX == `LCF_CMD_EXT_READ_A
		|| CMD_INDEX == `LCF_CMD_EXT_READ_B);
	assign is_ext      = is_ext_read || (!CMD_APP && (CMD_INDEX == `LCF_CMD_EXT_WRITE_A
		|| CMD_INDEX == `LCF_CMD_EXT_WRITE_B));
	assign is_lock_cmd = !CMD_APP && CMD_INDEX == `LCF_CMD_LOCK_UNLOCK;
	assign sec_fn      = (FUNCTION_NUMBER_FIELD == SEC_BOOT_FUNC);
	// basic class, lock/unlock command, block length, init and pull-up app commands
	assign always_ok   = CMD_BASIC_CLASS || is_lock_cmd
		|| (!CMD_APP && CMD_INDEX == `LCF_CMD_SET_BLOCKLEN)
		|| (CMD_APP && (CMD_INDEX == `LCF_ACMD_OP_COND
		|| CMD_INDEX == `LCF_ACMD_PULLUP));

	always_comb
	begin
		next_accept = 1'b1;
		if (CMD_PROTECT_CLASS)
			next_accept = is_user && !LOCKED_IN && STD_CAPACITY && HAS_PROT_CMDS;
		else if (is_rpu)
			next_accept = !CMD_APP && CMD_INDEX == `LCF_CMD_BLOCK_COUNT;
		else if (is_boot)
		begin
			// lock state plays no part here
			if (is_write || CMD_ERASE_CLASS)
				next_accept = REPLAY_DISABLED || REPLAY_AUTH_OK;
			else if (is_tune)
				next_accept = HAS_TUNING;
			else if (!CMD_APP && CMD_INDEX == `LCF_CMD_BLOCK_COUNT)
				next_accept = HAS_BLOCK_COUNT;
		end
		else if (!LOCKED_IN)
		begin
			if (is_tune)
				next_accept = HAS_TUNING;
			else if (!CMD_APP && CMD_INDEX == `LCF_CMD_BLOCK_COUNT)
				next_accept = HAS_BLOCK_COUNT;
			else if (is_ext)
				next_accept = HAS_SEC_BOOT;
		end
		else
		begin
			if (is_read || is_tune || is_write || CMD_ERASE_CLASS)
				next_accept = 1'b0;
			else if (!CMD_APP && CMD_INDEX == `LCF_CMD_BLOCK_COUNT)
				next_accept = HAS_SEC_DATA;
			else if (is_ext)
				next_accept = HAS_SEC_BOOT;
			else if (!CMD_APP && CMD_INDEX == `LCF_CMD_OPT_A)
				next_accept = HAS_OPT_CMD;
			else if (CMD_APP && (CMD_INDEX == `LCF_ACMD_SEC_A
				|| CMD_INDEX == `LCF_ACMD_SEC_B))
				next_accept = HAS_SEC_DATA;
			else
				next_accept = always_ok;
		end
	end

	// =====================================================
	// lock/unlock parameter resolution
	logic [3:0] next_param;
	logic       next_lock_err;
	logic       force_erase;

	assign force_erase = (LOCK_PARAM == `LCF_LK_ERASE);

	always_comb
	begin
		next_param    = LOCK_PARAM;
		next_lock_err = 1'b0;
		if (LOCK_PARAM == `LCF_LK_0011 || LOCK_PARAM == `LCF_LK_0111
			|| LOCK_PARAM == `LCF_LK_0110)
		begin
			if (NEWER_TYPE)
				next_lock_err = 1'b1;
			else if (LOCK_PARAM == `LCF_LK_0011)
				next_param = `LCF_LK_0001;
			else if (LOCK_PARAM == `LCF_LK_0111)
				next_param = `LCF_LK_0101;
			else
				next_param = `LCF_LK_0010;
		end
		if (NEWER_TYPE && LOCK_PARAM == `LCF_LK_0010 && ERASE_PWD_SET)
			next_lock_err = 1'b1;
		if (LOCK_ERASE_PWD_UNLOCK && !HAS_ERASE_PWD)
			next_lock_err = 1'b1;
		if (HAS_ERASE_PWD && ERASE_PWD_SET
			&& (force_erase || LOCK_PARAM == `LCF_LK_0010))
			next_lock_err = 1'b1;
		if (force_erase && PERMANENT_PROTECT_BIT && NEWER_TYPE)
			next_lock_err = 1'b1;
		if (force_erase && !LOCKED_IN)
			next_lock_err = 1'b1;
	end

	// =====================================================
	// per-command decision and response status
	logic ext_pending;
	logic ext_skip;
	logic busy_start;
	logic busy_active;

	assign ext_skip = next_accept && LOCKED_IN && is_ext && HAS_SEC_BOOT && !sec_fn;

	always_ff @(posedge CLK)
	begin
		if (!RESETN)
		begin
			CMD_ACCEPT        <= 1'b0;
			CMD_ILLEGAL       <= 1'b0;
			EXT_EXECUTE       <= 1'b0;
			EXT_SUPPRESS_DATA <= 1'b0;
			LOCKED_STATE_FLAG <= 1'b0;
			RANGE_ERROR_FLAG  <= 1'b0;
			ILLEGAL_FLAG      <= 1'b0;
			ext_pending       <= 1'b0;
			busy_start        <= 1'b0;
		end
		else
		begin
			busy_start <= 1'b0;
			CMD_ACCEPT <= 1'b0;
			CMD_ILLEGAL <= 1'b0;
			EXT_EXECUTE <= 1'b0;
			EXT_SUPPRESS_DATA <= 1'b0;
			if (CMD_VALID)
			begin
				CMD_ACCEPT  <= next_accept;
				CMD_ILLEGAL <= !next_accept;
				// illegal flag belongs to this command's own response
				ILLEGAL_FLAG <= !next_accept;
				LOCKED_STATE_FLAG <= LOCKED_IN && (next_accept || ext_pending);
				RANGE_ERROR_FLAG  <= ext_pending;
				EXT_EXECUTE <= next_accept && is_ext && (!LOCKED_IN || sec_fn);
				EXT_SUPPRESS_DATA <= ext_skip && is_ext_read;
				busy_start <= ext_skip && !is_ext_read;
				ext_pending <= ext_skip;
			end
		end
	end

	lcf_busy_timer #(
		.HOLD_CYC (EXT_BUSY_CYC)
	) u_busy (
		.clk    (CLK),
		.resetn (RESETN),
		.start  (busy_start),
		.busy   (busy_active)
	);

	always_ff @(posedge CLK)
	begin
		if (!RESETN)
			EXT_BUSY <= 1'b0;
		else
			EXT_BUSY <= busy_active;
	end

	// =====================================================
	// lock/unlock command outcome
	logic erase_running;

	always_ff @(posedge CLK)
	begin
		if (!RESETN)
		begin
			LOCK_ERROR_FLAG       <= 1'b0;
			LOCK_EXECUTE          <= 1'b0;
			LOCK_PARAM_EFF        <= 4'h0;
			ERASE_START           <= 1'b0;
			WRITE_ERASE_PWD       <= 1'b0;
			CLEAR_ERASE_PWD       <= 1'b0;
			WRITE_USER_PWD        <= 1'b0;
			CLEAR_USER_PWD        <= 1'b0;
		end
		else
		begin
			LOCK_EXECUTE    <= 1'b0;
			ERASE_START     <= 1'b0;
			WRITE_ERASE_PWD <= 1'b0;
			CLEAR_ERASE_PWD <= 1'b0;
			WRITE_USER_PWD  <= 1'b0;
			CLEAR_USER_PWD  <= 1'b0;
			if (CMD_VALID && is_lock_cmd)
			begin
				LOCK_ERROR_FLAG <= next_lock_err;
				LOCK_PARAM_EFF  <= next_param;
				// an illegal lock command still reports its status but changes nothing
				if (!next_lock_err && next_accept)
				begin
					LOCK_EXECUTE    <= 1'b1;
					ERASE_START     <= force_erase;
					WRITE_ERASE_PWD <= LOCK_SET_ERASE_PWD && HAS_ERASE_PWD;
					CLEAR_ERASE_PWD <= LOCK_CLR_ERASE_PWD && HAS_ERASE_PWD;
					WRITE_USER_PWD  <= LOCK_SET_ERASE_PWD && !HAS_ERASE_PWD;
					CLEAR_USER_PWD  <= LOCK_CLR_ERASE_PWD && !HAS_ERASE_PWD;
				end
			end
		end
	end

	// protection changes wait for the whole user area to be erased
	always_ff @(posedge CLK)
	begin
		if (!RESETN)
		begin
			erase_running         <= 1'b0;
			SET_PERMANENT_PROTECT <= 1'b0;
			CLEAR_TEMP_PROTECTS   <= 1'b0;
			CLEAR_LOCK            <= 1'b0;
		end
		else
		begin
			SET_PERMANENT_PROTECT <= 1'b0;
			CLEAR_TEMP_PROTECTS   <= 1'b0;
			CLEAR_LOCK            <= 1'b0;
			if (ERASE_START)
				erase_running <= 1'b1;
			else if (erase_running && ERASE_DONE)
			begin
				erase_running         <= 1'b0;
				CLEAR_LOCK            <= 1'b1;
				// earlier type: erase wins and protection becomes permanent when PERMANENT_PROTECT_BIT is set
				SET_PERMANENT_PROTECT <= !NEWER_TYPE && PERMANENT_PROTECT_BIT;
				CLEAR_TEMP_PROTECTS   <= NEWER_TYPE;
			end
		end
	end
endmodule : lcf_filter

// ===== lcf_checker.sv
// assertion checker for lcf_filter, watching top-level ports only
// assumes a bind from the bench and the single CLK domain
`timescale 1ns/10ps
`include "lcf_consts.svh"
module lcf_checker #(
	parameter bit          STD_CAPACITY  = 1'b0,
	parameter logic [3:0]  SEC_BOOT_FUNC = 4'h1,
	parameter int unsigned EXT_BUSY_CYC  = 20
) (
	input wire logic       CLK,
	input wire logic       RESETN,
	input wire logic       CMD_VALID,
	input wire logic [5:0] CMD_INDEX,
	input wire logic       CMD_APP,
	input wire logic       CMD_PROTECT_CLASS,
	input wire logic [2:0] CMD_TARGET,
	input wire logic [3:0] FUNCTION_NUMBER_FIELD,
	input wire logic [3:0] LOCK_PARAM,
	input wire logic       LOCKED_IN,
	input wire logic       REPLAY_AUTH_OK,
	input wire logic       REPLAY_DISABLED,
	input wire logic       ERASE_DONE,
	input wire logic       CMD_ACCEPT,
	input wire logic       CMD_ILLEGAL,
	input wire logic       EXT_EXECUTE,
	input wire logic       EXT_BUSY,
	input wire logic       LOCKED_STATE_FLAG,
	input wire logic       LOCK_ERROR_FLAG,
	input wire logic       LOCK_EXECUTE,
	input wire logic       ERASE_START,
	input wire logic       CLEAR_LOCK
);
	// ==========================================================
	// helpers
	logic        user_rw;
	logic        boot_wr;
	logic        ext_cmd;
	logic [31:0] busy_cnt;

	assign user_rw = !CMD_APP && CMD_TARGET == 3'h1 && CMD_INDEX inside {`LCF_CMD_READ_SINGLE,
		`LCF_CMD_READ_MULTI, `LCF_CMD_WRITE_SINGLE, `LCF_CMD_WRITE_MULTI};
	assign boot_wr = !CMD_APP && CMD_TARGET == 3'h2
		&& CMD_INDEX inside {`LCF_CMD_WRITE_SINGLE, `LCF_CMD_WRITE_MULTI};
	assign ext_cmd = !CMD_APP && CMD_INDEX inside {`LCF_CMD_EXT_READ_A, `LCF_CMD_EXT_WRITE_A,
		`LCF_CMD_EXT_READ_B, `LCF_CMD_EXT_WRITE_B};

	// counts busy cycles so the hold length is checked without long repetitions
	always_ff @(posedge CLK)
	begin
		if (!RESETN || !EXT_BUSY)
			busy_cnt <= 32'h0;
		else
			busy_cnt <= busy_cnt + 32'h1;
	end

	// ==========================================================
	// properties
	default clocking cb @(posedge CLK); endclocking
	default disable iff (!RESETN);

	sequence s_locked_accept;
		CMD_VALID && LOCKED_IN ##1 CMD_ACCEPT;
	endsequence
	sequence s_sec_ext;
		CMD_VALID && LOCKED_IN && ext_cmd && FUNCTION_NUMBER_FIELD == SEC_BOOT_FUNC;
	endsequence

	a_one_verdict: assert property (CMD_VALID |=> CMD_ACCEPT ^ CMD_ILLEGAL)
		else $error("command without exactly one verdict");
	a_verdict_cause: assert property ((CMD_ACCEPT || CMD_ILLEGAL) |-> $past(CMD_VALID))
		else $error("verdict without command");
	a_user_locked: assert property (CMD_VALID && LOCKED_IN && user_rw |=> CMD_ILLEGAL)
		else $error("locked user access not illegal");
	a_protect_gate: assert property (CMD_VALID && CMD_PROTECT_CLASS
		&& (LOCKED_IN || CMD_TARGET != 3'h1 || !STD_CAPACITY) |=> CMD_ILLEGAL)
		else $error("protect command not illegal");
	a_boot_write: assert property (CMD_VALID && boot_wr
		&& !REPLAY_DISABLED && !REPLAY_AUTH_OK |=> CMD_ILLEGAL)
		else $error("boot write without auth accepted");
	a_locked_flag: assert property (s_locked_accept |-> LOCKED_STATE_FLAG)
		else $error("locked flag missing");
	a_sec_ext: assert property (s_sec_ext |=> CMD_ACCEPT && EXT_EXECUTE)
		else $error("security extension not executed");
	a_busy_length: assert property ($fell(EXT_BUSY) |-> busy_cnt == EXT_BUSY_CYC)
		else $error("busy hold length wrong");
	a_lock_param: assert property (CMD_VALID && !CMD_APP && CMD_INDEX == `LCF_CMD_LOCK_UNLOCK
		&& LOCK_PARAM inside {4'h3, 4'h7, 4'h6} |=> LOCK_ERROR_FLAG && !LOCK_EXECUTE)
		else $error("bad lock parameter not refused");
	a_clear_after_done: assert property (CLEAR_LOCK |-> $past(ERASE_DONE))
		else $error("lock cleared without erase done");
	a_illegal_inert: assert property (CMD_ILLEGAL |-> !EXT_EXECUTE && !LOCK_EXECUTE && !ERASE_START)
		else $error("illegal command had effect");
endmodule : lcf_checker

// ===== lcf_host_model.sv
// host side model: the card bus clock source
// assumes the bench raises frame around each burst of host traffic
`timescale 1ns/10ps
module lcf_host_model #(
	parameter realtime HALF = 40.0
) (
	input  wire logic frame,
	output logic      card_clk
);
	// ==========================================================
	// gated clock: stands low between frames as a real host leaves it
	initial
	begin
		card_clk = 1'b0;
		forever
		begin
			wait (frame);
			#HALF card_clk = 1'b1;
			#HALF card_clk = 1'b0;
		end
	end
endmodule : lcf_host_model

// ===== tb_locked_card_command_filter.sv
// self-checking bench for lcf_filter with the host clock model
// assumes lcf_consts.svh, lcf_filter, lcf_host_model and lcf_checker
`timescale 1ns/10ps
`include "lcf_consts.svh"
module tb_locked_card_command_filter;
	logic       CLK, RESETN, CARD_CLK_IN, CMD_VALID, CMD_APP, CMD_ERASE_CLASS, frame;
	logic       CMD_PROTECT_CLASS, CMD_BASIC_CLASS, LOCK_ERASE_PWD_UNLOCK, LOCK_SET_ERASE_PWD;
	logic       LOCK_CLR_ERASE_PWD, LOCKED_IN, REPLAY_AUTH_OK, REPLAY_DISABLED, ERASE_PWD_SET;
	logic       PERMANENT_PROTECT_BIT, ERASE_DONE, CMD_ACCEPT, CMD_ILLEGAL, EXT_EXECUTE;
	logic       EXT_SUPPRESS_DATA, EXT_BUSY, LOCKED_STATE_FLAG, RANGE_ERROR_FLAG, ILLEGAL_FLAG;
	logic       LOCK_ERROR_FLAG, LOCK_EXECUTE, ERASE_START, SET_PERMANENT_PROTECT, CLEAR_LOCK;
	logic       CLEAR_TEMP_PROTECTS, WRITE_ERASE_PWD, CLEAR_ERASE_PWD, WRITE_USER_PWD;
	logic       CLEAR_USER_PWD, CARD_CLK_EDGE;
	logic [5:0] CMD_INDEX;
	logic [2:0] CMD_TARGET;
	logic [3:0] FUNCTION_NUMBER_FIELD, LOCK_PARAM, LOCK_PARAM_EFF;
	logic [5:0] ua [5] = '{6'h11, 6'h12, 6'h13, 6'h18, 6'h19};
	logic [3:0] bad [3] = '{4'h3, 4'h7, 4'h6};
	int         fails, n_tests, cnt;

	// ==========================================================
	// design, host model, clock
	lcf_filter #(.EXT_BUSY_CYC(20)) lcf_filter_i (.*);
	lcf_host_model lcf_host_model_i (.frame(frame), .card_clk(CARD_CLK_IN));

	initial
	begin
		CLK = 1'b0;
		forever
			#4 CLK = ~CLK;
	end

	// ==========================================================
	// shared tasks
	task automatic chk(input logic got, input logic exp);
		n_tests++;
		if (got !== exp)
		begin
			fails++;
			$display("BAD %0t got %b exp %b", $time, got, exp);
		end
	endtask : chk

	task automatic issue(input logic [5:0] idx, input logic [2:0] tgt, input logic [3:0] fn,
		input logic [3:0] prm);
		@(negedge CLK);
		CMD_INDEX = idx;
		CMD_TARGET = tgt;
		FUNCTION_NUMBER_FIELD = fn;
		LOCK_PARAM = prm;
		CMD_VALID = 1'b1;
		@(negedge CLK);
		// verdict pulses stand only until the next edge, so callers judge here
		CMD_VALID = 1'b0;
	endtask : issue

	task automatic complete_run;
		$display("tests %0d fails %0d", n_tests, fails);
		if (fails == 0 && n_tests > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask : complete_run

	// ==========================================================
	// scenarios
	task automatic t_user;
		LOCKED_IN = 1'b1;
		foreach (ua[i])
		begin
			issue(ua[i], 3'h1, 4'h0, 4'h0);
			chk(CMD_ILLEGAL, 1'b1);
			chk(ILLEGAL_FLAG, 1'b1);
		end
		CMD_ERASE_CLASS = 1'b1;
		issue(6'h20, 3'h1, 4'h0, 4'h0);
		chk(CMD_ILLEGAL, 1'b1);
		CMD_ERASE_CLASS = 1'b0;
		LOCKED_IN = 1'b0;
		issue(6'h19, 3'h1, 4'h0, 4'h0);
		chk(CMD_ACCEPT, 1'b1);
		chk(LOCKED_STATE_FLAG, 1'b0);
		$display("done user area");
	endtask : t_user

	task automatic t_count_boot;
		LOCKED_IN = 1'b1;
		issue(6'h17, 3'h1, 4'h0, 4'h0);
		chk(CMD_ACCEPT, 1'b1);
		chk(LOCKED_STATE_FLAG, 1'b1);
		issue(6'h17, 3'h4, 4'h0, 4'h0);
		chk(CMD_ACCEPT, 1'b1);
		issue(6'h18, 3'h2, 4'h0, 4'h0);
		chk(CMD_ILLEGAL, 1'b1);
		REPLAY_AUTH_OK = 1'b1;
		issue(6'h18, 3'h2, 4'h0, 4'h0);
		chk(CMD_ACCEPT, 1'b1);
		REPLAY_AUTH_OK = 1'b0;
		CMD_PROTECT_CLASS = 1'b1;
		LOCKED_IN = 1'b0;
		issue(6'h1c, 3'h1, 4'h0, 4'h0);
		chk(CMD_ILLEGAL, 1'b1);
		CMD_PROTECT_CLASS = 1'b0;
		$display("done count boot protect");
	endtask : t_count_boot

	task automatic t_ext;
		LOCKED_IN = 1'b1;
		CMD_BASIC_CLASS = 1'b1;
		issue(6'h31, 3'h1, 4'h1, 4'h0);
		chk(EXT_EXECUTE, 1'b1);
		chk(LOCKED_STATE_FLAG, 1'b1);
		issue(6'h3a, 3'h1, 4'h2, 4'h0);
		chk(EXT_SUPPRESS_DATA, 1'b1);
		issue(6'h0d, 3'h1, 4'h0, 4'h0);
		chk(RANGE_ERROR_FLAG, 1'b1);
		chk(LOCKED_STATE_FLAG, 1'b1);
		issue(6'h3b, 3'h1, 4'h2, 4'h0);
		cnt = 0;
		repeat (60)
		begin
			if (EXT_BUSY === 1'b1)
				cnt++;
			@(negedge CLK);
		end
		chk(cnt == 20, 1'b1);
		issue(6'h0d, 3'h1, 4'h0, 4'h0);
		chk(RANGE_ERROR_FLAG, 1'b1);
		issue(6'h0d, 3'h1, 4'h0, 4'h0);
		chk(RANGE_ERROR_FLAG, 1'b0);
		CMD_BASIC_CLASS = 1'b0;
		$display("done extension");
	endtask : t_ext

	task automatic t_lock;
		foreach (bad[i])
		begin
			issue(6'h2a, 3'h1, 4'h0, bad[i]);
			chk(LOCK_ERROR_FLAG, 1'b1);
			chk(LOCK_EXECUTE, 1'b0);
		end
		// deliberately against host advice, to see the newer-type refusal
		PERMANENT_PROTECT_BIT = 1'b1;
		issue(6'h2a, 3'h1, 4'h0, 4'h8);
		chk(LOCK_ERROR_FLAG, 1'b1);
		chk(ERASE_START, 1'b0);
		PERMANENT_PROTECT_BIT = 1'b0;
		issue(6'h2a, 3'h1, 4'h0, 4'h8);
		chk(ERASE_START, 1'b1);
		// erase engine finishes only after the erase has been seen running
		@(negedge CLK);
		ERASE_DONE = 1'b1;
		@(negedge CLK);
		ERASE_DONE = 1'b0;
		chk(CLEAR_LOCK, 1'b1);
		chk(CLEAR_TEMP_PROTECTS, 1'b1);
		chk(SET_PERMANENT_PROTECT, 1'b0);
		ERASE_PWD_SET = 1'b1;
		issue(6'h2a, 3'h1, 4'h0, 4'h8);
		chk(LOCK_ERROR_FLAG, 1'b1);
		chk(ERASE_START, 1'b0);
		issue(6'h2a, 3'h1, 4'h0, 4'h2);
		chk(LOCK_ERROR_FLAG, 1'b1);
		ERASE_PWD_SET = 1'b0;
		LOCKED_IN = 1'b0;
		LOCK_SET_ERASE_PWD = 1'b1;
		issue(6'h2a, 3'h1, 4'h0, 4'h1);
		chk(WRITE_ERASE_PWD, 1'b1);
		chk(WRITE_USER_PWD, 1'b0);
		chk(LOCK_PARAM_EFF == `LCF_LK_0001, 1'b1);
		LOCK_SET_ERASE_PWD = 1'b0;
		LOCK_CLR_ERASE_PWD = 1'b1;
		issue(6'h2a, 3'h1, 4'h0, 4'h2);
		chk(CLEAR_ERASE_PWD, 1'b1);
		chk(CLEAR_USER_PWD, 1'b0);
		LOCK_CLR_ERASE_PWD = 1'b0;
		$display("done lock and erase");
	endtask : t_lock

	task automatic t_link;
		cnt = 0;
		frame = 1'b1;
		repeat (70)
		begin
			@(negedge CLK);
			if (CARD_CLK_EDGE === 1'b1)
				cnt++;
			if (cnt == 5)
				frame = 1'b0;
		end
		chk(cnt == 5, 1'b1);
		$display("done link clock");
	endtask : t_link

	// ==========================================================
	// main sequence
	initial
	begin
		{RESETN, CMD_VALID, CMD_APP, CMD_ERASE_CLASS, CMD_PROTECT_CLASS, CMD_BASIC_CLASS} = '0;
		{LOCK_ERASE_PWD_UNLOCK, LOCK_SET_ERASE_PWD, LOCK_CLR_ERASE_PWD, LOCKED_IN} = '0;
		{REPLAY_AUTH_OK, REPLAY_DISABLED, ERASE_PWD_SET, PERMANENT_PROTECT_BIT} = '0;
		{ERASE_DONE, frame, CMD_INDEX, CMD_TARGET, FUNCTION_NUMBER_FIELD, LOCK_PARAM} = '0;
		fails = 0;
		n_tests = 0;
		repeat (8)
			@(negedge CLK);
		RESETN = 1'b1;
		t_user();
		t_count_boot();
		t_ext();
		t_lock();
		t_link();
		complete_run();
	end
endmodule : tb_locked_card_command_filter

bind lcf_filter lcf_checker #(
	.STD_CAPACITY (STD_CAPACITY),
	.SEC_BOOT_FUNC(SEC_BOOT_FUNC),
	.EXT_BUSY_CYC (EXT_BUSY_CYC)
) lcf_checker_i (.*);
